// File: core/odp_pin_if.sv
// Pin-level control of an output driver: serial port or hardware straps.
// Assumes APB master on pclk, serial master driving serial_clk and
// frame_latch, and analog logic reading the drive control outputs.
`timescale 1ns/1ps

module odp_pin_if import odp_pkg::*; (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial and strap pins
  input  wire logic        serial_clk,
  input  wire logic        frame_latch,
  input  wire logic        serial_in,
  input  wire logic        bus_addr_bit0,
  input  wire logic        bus_addr_bit1,
  input  wire logic        bus_addr_bit2,
  input  wire logic        clear_in,
  input  wire logic        clear_value_select,
  input  wire logic        hw_mode_select,
  input  wire logic        short_circuit_detect,
  output logic             serial_out,
  output logic             serial_out_oe_n,
  // Drive control to the analog side
  output logic      [3:0]  range_setting,
  output logic             drive_enable,
  output logic             sense_internal,
  output logic             clear_force,
  output logic             clear_midscale,
  output logic             vout_powerup_active
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [NPIN-1:0] s1_reg, s2_reg, s3_reg, pin_reg;
  odp_boot_t       boot_reg;
  logic [2:0]      boot_cnt_reg;
  logic            hw_reg, vout_reg, latch_d_reg, cnt_clr_reg;
  logic            pec_en_reg;
  logic            clr_bit_reg, csel_bit_reg, oe_bit_reg, rsel_bit_reg;
  logic [3:0]      range_bit_reg;
  logic [15:0]     frame_reg, drop_reg;
  logic [SR_W-1:0] shift_reg;
  logic [4:0]      cnt_reg;
  logic            so_reg, oe_n_reg;
  logic            lnk_rst_n, sw_run, rise, frame_ok, addr_ok;
  logic [15:0]     word;
  logic [2:0]      addr_s;
  logic [3:0]      hw_range;

  // Keep a per-bit value only once the two late stages agree
  function automatic logic [NPIN-1:0] settle(
    input logic [NPIN-1:0] a,
    input logic [NPIN-1:0] b,
    input logic [NPIN-1:0] hold);
    return (a & b) | (hold & (a ^ b));
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisers (pclk)
  // ---------------------------------------------------------------
  // Three stages; first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      pin_reg <= '0;
    end else begin
      s1_reg  <= {short_circuit_detect, hw_mode_select,
                  clear_value_select, clear_in, frame_latch,
                  serial_clk, serial_in, bus_addr_bit2,
                  bus_addr_bit1, bus_addr_bit0};
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      pin_reg <= settle(s2_reg, s3_reg, pin_reg);
    end
  end

  // ---------------------------------------------------------------
  // Power-up mode capture
  // ---------------------------------------------------------------
  // Wait for the synchronisers to fill before trusting the straps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_reg     <= ST_BOOT;
      boot_cnt_reg <= 3'h0;
      hw_reg       <= 1'b0;
      vout_reg     <= 1'b0;
    end else begin
      unique case (boot_reg)
        ST_BOOT: begin
          boot_cnt_reg <= boot_cnt_reg + 3'h1;
          if (boot_cnt_reg == BOOT_CYCLES - 3'h1) begin
            boot_reg <= ST_RUN;
            hw_reg   <= pin_reg[P_HWS];
            vout_reg <= ~pin_reg[P_HWS] & pin_reg[P_CLR];
          end
        end
        ST_RUN: begin
          boot_cnt_reg <= boot_cnt_reg;
        end
      endcase
    end
  end

  assign sw_run = (boot_reg == ST_RUN) & ~hw_reg;

  // ---------------------------------------------------------------
  // Serial link domain (serial_clk)
  // ---------------------------------------------------------------
  // Count is cleared from the pclk side after each frame; no link
  // edges arrive then because the latch is still high.
  assign lnk_rst_n = presetn & ~cnt_clr_reg;

  // Capture on falling edge, frozen while latch is high
  always_ff @(negedge serial_clk or negedge presetn) begin
    if (!presetn) begin
      shift_reg <= '0;
    end else if (sw_run && !frame_latch) begin
      shift_reg <= {shift_reg[SR_W-2:0], serial_in};
    end
  end

  // Falling edges seen in the current frame, saturating
  always_ff @(negedge serial_clk or negedge lnk_rst_n) begin
    if (!lnk_rst_n) begin
      cnt_reg <= 5'h0;
    end else if (sw_run && !frame_latch && cnt_reg != CNT_MAX) begin
      cnt_reg <= cnt_reg + 5'h1;
    end
  end

  // Readback bit launched on rising edge for host falling-edge sample
  always_ff @(posedge serial_clk or negedge presetn) begin
    if (!presetn) begin
      so_reg <= 1'b0;
    end else if (!frame_latch) begin
      so_reg <= pec_en_reg ? shift_reg[SR_W-1] : shift_reg[15];
    end
  end

  // Push-pull in software mode, open-drain alert in hardware mode
  assign serial_out = hw_reg ? 1'b0 : so_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_n_reg <= 1'b0;
    end else begin
      oe_n_reg <= hw_reg & ~pin_reg[P_SHRT];
    end
  end
  assign serial_out_oe_n = oe_n_reg;

  // ---------------------------------------------------------------
  // Frame acceptance (pclk)
  // ---------------------------------------------------------------
  // Link data is static here: the latch holds the link still
  assign rise     = sw_run & pin_reg[P_LAT] & ~latch_d_reg;
  assign word     = pec_en_reg ? shift_reg[23:8] : shift_reg[15:0];
  assign frame_ok = cnt_reg >= (pec_en_reg ? LEN_PEC : LEN_PLAIN);
  assign addr_s   = {pin_reg[P_AD2], pin_reg[P_AD1], pin_reg[P_AD0]};
  assign addr_ok  = word[FR_ADDR_LSB+:3] == addr_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_d_reg <= 1'b1;                                     // Idle level
      cnt_clr_reg <= 1'b0;
    end else begin
      latch_d_reg <= pin_reg[P_LAT];
      cnt_clr_reg <= rise;
    end
  end

  // Parallel load of internal state on an accepted frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clr_bit_reg   <= 1'b0;
      csel_bit_reg  <= 1'b0;
      oe_bit_reg    <= 1'b0;
      rsel_bit_reg  <= 1'b0;
      range_bit_reg <= 4'h0;
      frame_reg     <= 16'h0;
    end else if (rise && frame_ok && addr_ok) begin
      clr_bit_reg   <= word[FR_CLR];
      csel_bit_reg  <= word[FR_CLEAR_VALUE_SELECT];
      oe_bit_reg    <= word[FR_OE];
      rsel_bit_reg  <= word[FR_RSEL];
      range_bit_reg <= word[FR_RANGE_LSB+:4];
      frame_reg     <= word;
    end
  end

  // Short frames counted so software can spot a noisy link
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drop_reg <= 16'h0;
    end else if (rise && !frame_ok) begin
      drop_reg <= drop_reg + 16'h1;
    end
  end

  // ---------------------------------------------------------------
  // Drive control outputs
  // ---------------------------------------------------------------
  // Range pins share the address and data pins in hardware mode
  assign hw_range = {pin_reg[P_AD0], pin_reg[P_AD1],
                     pin_reg[P_AD2], pin_reg[P_SDI]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      range_setting  <= 4'h0;
      drive_enable   <= 1'b0;
      sense_internal <= 1'b0;
      clear_force    <= 1'b0;
      clear_midscale <= 1'b0;
    end else begin
      range_setting  <= hw_reg ? hw_range : range_bit_reg;
      drive_enable   <= hw_reg ? pin_reg[P_SCK] : oe_bit_reg;
      sense_internal <= hw_reg ? pin_reg[P_LAT] : rsel_bit_reg;
      clear_force    <= pin_reg[P_CLR] |
                        (~hw_reg & clr_bit_reg);
      clear_midscale <= pin_reg[P_CSEL] |
                        (~hw_reg & csel_bit_reg);
    end
  end
  assign vout_powerup_active = vout_reg;

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  // Zero wait states; data is loaded in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable &
                   (paddr != A_CTRL) & (paddr != A_STATUS) &
                   (paddr != A_FRAME) & (paddr != A_DROP);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pec_en_reg <= CTRL_RST;
    end else if (psel && penable && pwrite && paddr == A_CTRL) begin
      pec_en_reg <= pwdata[CTRL_PEC_EN];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable) begin
      unique case (paddr)
        A_CTRL:   prdata <= {31'h0, pec_en_reg};
        A_STATUS: prdata <= {20'h0, boot_reg == ST_RUN, hw_reg,
                             vout_reg, clear_force, clear_midscale,
                             drive_enable, sense_internal,
                             pin_reg[P_SHRT], range_setting};
        A_FRAME:  prdata <= {16'h0, frame_reg};
        A_DROP:   prdata <= {16'h0, drop_reg};
        default:  prdata <= 32'h0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_push_pull;
    @(posedge pclk) disable iff (!presetn)
    sw_run |-> !serial_out_oe_n;
  endproperty
  a_push_pull: assert property (p_push_pull)
    else $error("serial output not driven in software mode");

  property p_alert;
    @(posedge pclk) disable iff (!presetn)
    hw_reg ##1 hw_reg |-> serial_out == 1'b0 &&
      serial_out_oe_n == !$past(pin_reg[P_SHRT]);
  endproperty
  a_alert: assert property (p_alert)
    else $error("alert pin does not follow short circuit");

  property p_clear_value_select;
    @(posedge pclk) disable iff (!presetn)
    pin_reg[P_CSEL] |=> clear_midscale;
  endproperty
  a_clear_value_select: assert property (p_clear_value_select)
    else $error("clear select pin ignored");

  property p_clear;
    @(posedge pclk) disable iff (!presetn)
    (pin_reg[P_CLR] || (sw_run && clr_bit_reg)) |=> clear_force;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear not forced");

  property p_load;
    @(posedge pclk) disable iff (!presetn)
    rise && frame_ok && addr_ok |=> frame_reg == $past(word) &&
      range_bit_reg == $past(word[3:0]);
  endproperty
  a_load: assert property (p_load)
    else $error("accepted frame not loaded");

  property p_discard;
    @(posedge pclk) disable iff (!presetn)
    rise && !(frame_ok && addr_ok) |=> $stable(frame_reg) &&
      $stable(clr_bit_reg) && $stable(range_bit_reg);
  endproperty
  a_discard: assert property (p_discard)
    else $error("short or foreign frame changed state");

  property p_hw_pins;
    @(posedge pclk) disable iff (!presetn)
    hw_reg ##1 hw_reg |-> sense_internal == $past(pin_reg[P_LAT]) &&
      drive_enable == $past(pin_reg[P_SCK]) &&
      range_setting == $past(hw_range);
  endproperty
  a_hw_pins: assert property (p_hw_pins)
    else $error("hardware mode pins not decoded");

  property p_mode_fixed;
    @(posedge pclk) disable iff (!presetn)
    boot_reg == ST_RUN |=> $stable(hw_reg) && $stable(vout_reg);
  endproperty
  a_mode_fixed: assert property (p_mode_fixed)
    else $error("mode changed after power-up");

  property p_shift;
    @(negedge serial_clk) disable iff (!presetn)
    sw_run && !frame_latch ##1 sw_run && !frame_latch |->
      shift_reg[0] == $past(serial_in);
  endproperty
  a_shift: assert property (p_shift)
    else $error("serial bit not captured");

  property p_frozen;
    @(negedge serial_clk) disable iff (!presetn)
    frame_latch |-> ##0 1'b1 ##1 $stable(shift_reg) || !frame_latch;
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("shift register moved while latch high");

  c_accept:  cover property (@(posedge pclk) rise && frame_ok && addr_ok);
  c_short:   cover property (@(posedge pclk) rise && !frame_ok);
  c_foreign: cover property (@(posedge pclk) rise && frame_ok && !addr_ok);
  c_hw:      cover property (@(posedge pclk) hw_reg && !serial_out_oe_n);

endmodule

// File: common/odp_pkg.sv
// Constants for the output driver pin interface.
// Assumes one APB slave on pclk and a serial link on its own clock.
package odp_pkg;

  // ---------------------------------------------------------------
  // APB register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_FRAME  = 8'h08;
  localparam logic [7:0] A_DROP   = 8'h0c;
  localparam int CTRL_PEC_EN      = 0;
  localparam logic CTRL_RST       = 1'b0;

  // ---------------------------------------------------------------
  // Pin synchroniser vector positions
  // ---------------------------------------------------------------
  localparam int NPIN   = 10;
  localparam int P_AD0  = 0;
  localparam int P_AD1  = 1;
  localparam int P_AD2  = 2;
  localparam int P_SDI  = 3;
  localparam int P_SCK  = 4;
  localparam int P_LAT  = 5;
  localparam int P_CLR  = 6;
  localparam int P_CSEL = 7;
  localparam int P_HWS  = 8;
  localparam int P_SHRT = 9;

  // ---------------------------------------------------------------
  // Frame layout and lengths
  // ---------------------------------------------------------------
  localparam int SR_W       = 24;
  localparam logic [4:0] LEN_PLAIN = 5'd16;
  localparam logic [4:0] LEN_PEC   = 5'd24;
  localparam logic [4:0] CNT_MAX   = 5'd31;
  localparam int FR_ADDR_LSB = 13;
  localparam int FR_CLR      = 12;
  localparam int FR_CLEAR_VALUE_SELECT   = 11;
  localparam int FR_OE       = 10;
  localparam int FR_RSEL     = 9;
  localparam int FR_RANGE_LSB = 0;

  // ---------------------------------------------------------------
  // Power-up sequence
  // ---------------------------------------------------------------
  localparam logic [2:0] BOOT_CYCLES = 3'd5;
  typedef enum logic {
    ST_BOOT = 1'b0,
    ST_RUN  = 1'b1
  } odp_boot_t;

endpackage

// File: tb/odp_host_model.sv
// Host serial master model for the link pins of the pin block.
// Assumes the device samples serial_in on falling link clock edges.
`timescale 1ns/1ps
module odp_host_model (
  // Link pins
  output logic      serial_clk,
  output logic      frame_latch,
  output logic      serial_in,
  // Readback
  input  wire logic serial_out
);
  logic rb_q[$];

  // ---------------------------------------------------------------
  // Idle: latch high, clock parked high between frames
  // ---------------------------------------------------------------
  initial begin
    serial_clk  = 1'b1;
    frame_latch = 1'b1;
    serial_in   = 1'b0;
  end

  // Send n bits MSB first; readback is sampled just before each fall
  task automatic send(input logic [31:0] w, input int n);
    rb_q.delete();
    #3.3 frame_latch = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = w[i];
      #16 rb_q.push_back(serial_out);
      serial_clk = 1'b0;
      #32 serial_clk = 1'b1;
      #16;
    end
    frame_latch = 1'b1;
    // Released data line must not keep showing the last bit
    serial_in = ~serial_in;
    // Latch stays high past 8 pclk so the edge count clears
    #100;
  endtask

  // Hardware mode: the link pins become static straps
  task automatic set_pins(input logic sck, input logic lat,
                          input logic sdi);
    serial_clk  = sck;
    frame_latch = lat;
    serial_in   = sdi;
  endtask
endmodule

// File: tb/testbench.sv
// Self-checking bench: software frames, APB registers, hardware straps.
// Assumes odp_host_model drives the link pins on its own 64 ns clock.
`timescale 1ns/1ps
module testbench import odp_pkg::*; ;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, w, rd;
  logic        serial_clk, frame_latch, serial_in, serial_out, so_oe_n;
  logic        ad0, ad1, ad2, clear_in, cvs, hw_sel, shrt, err;
  logic [3:0]  range_setting;
  logic        drive_enable, sense_internal, clr_f, clr_m, vout_pu;
  logic [15:0] m_word;
  logic [2:0]  dev;
  int          fail_count, checked, seed, m_drop;

  odp_host_model host (.serial_clk(serial_clk), .frame_latch(frame_latch),
    .serial_in(serial_in), .serial_out(serial_out));

  odp_pin_if DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_clk(serial_clk), .frame_latch(frame_latch),
    .serial_in(serial_in), .bus_addr_bit0(ad0), .bus_addr_bit1(ad1),
    .bus_addr_bit2(ad2), .clear_in(clear_in), .clear_value_select(cvs),
    .hw_mode_select(hw_sel), .short_circuit_detect(shrt),
    .serial_out(serial_out), .serial_out_oe_n(so_oe_n),
    .range_setting(range_setting), .drive_enable(drive_enable),
    .sense_internal(sense_internal), .clear_force(clr_f),
    .clear_midscale(clr_m), .vout_powerup_active(vout_pu));

  // ---------------------------------------------------------------
  // Clock, watchdog and shared tasks
  // ---------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Whole run is about 16 us; a hang ends well after that
  initial begin
    #200000;
    fail_count++;
    finish_test();
  end

  task automatic finish_test;
    if (fail_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (n >= 50) fail_count++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [31:0] e, input logic [31:0] msk);
    apb(1'b0, a, 32'h0);
    chk(nm, e & msk, rd & msk);
    chk("pslverr", 1'b0, err);
  endtask

  // Drive outputs against the last accepted frame word
  task automatic check_drive;
    chk("range", m_word[3:0], range_setting);
    chk("drive_en", m_word[10], drive_enable);
    chk("sense_int", m_word[9], sense_internal);
    chk("clr_force", m_word[12] | clear_in, clr_f);
    chk("clr_mid", m_word[11] | cvs, clr_m);
    chk("oe_n", 1'b0, so_oe_n);
  endtask

  task automatic do_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (12) @(posedge pclk);
    m_word = 16'h0;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 7922;
    fail_count = 0;
    checked = 0;
    m_drop = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    {ad2, ad1, ad0} = 3'h0;
    clear_in = 1'b1;
    cvs = 1'b0;
    hw_sel = 1'b0;
    shrt = 1'b0;
    do_reset();
    chk("vout_pu", 1'b1, vout_pu);
    check_drive();
    dev = 3'($random(seed));
    @(posedge pclk);
    clear_in <= 1'b0;
    {ad2, ad1, ad0} <= dev;
    repeat (10) @(posedge pclk);
    // Long and plain frames; every fourth carries a foreign address
    for (int i = 0; i < 8; i++) begin
      w = $random(seed);
      w[15:13] = (i % 4 == 3) ? dev + 3'd1 : dev;
      host.send(w, (i % 2 != 0) ? 16 : 24);
      if (i % 4 != 3) m_word = w[15:0];
      check_drive();
      if (i % 2 == 0)
        for (int k = 16; k < 24; k++)
          chk("readback", w[39-k], host.rb_q[k]);
    end
    // Clock pulses with the latch high must neither count nor shift
    repeat (2) begin
      host.set_pins(1'b0, 1'b1, 1'b1);
      repeat (8) @(posedge pclk);
      host.set_pins(1'b1, 1'b1, 1'b0);
      repeat (8) @(posedge pclk);
    end
    host.send($random(seed), 15);
    m_drop++;
    check_drive();
    rd_chk("drop", A_DROP, m_drop, 32'hffff);
    // Check byte mode: 24 edges needed, 16 now too few
    apb(1'b1, A_CTRL, 32'h1);
    rd_chk("ctrl", A_CTRL, 32'h1, 32'h1);
    w = $random(seed);
    w[23:21] = dev;
    host.send(w, 24);
    m_word = w[23:8];
    check_drive();
    rd_chk("frame", A_FRAME, m_word, 32'hffff);
    host.send(w, 16);
    m_drop++;
    rd_chk("drop", A_DROP, m_drop, 32'hffff);
    apb(1'b1, A_CTRL, 32'h0);
    // Clear pins; status is read only, unmapped space errors
    @(posedge pclk);
    clear_in <= 1'b1;
    cvs <= 1'b1;
    repeat (10) @(posedge pclk);
    check_drive();
    apb(1'b1, A_STATUS, 32'h0);
    rd_chk("status", A_STATUS, {20'h0, 3'b101, 2'b11, m_word[10],
      m_word[9], 1'b0, m_word[3:0]}, 32'hfff);
    apb(1'b0, 8'h10, 32'h0);
    chk("slverr", 1'b1, err);
    chk("unmapped", 32'h0, rd);
    // Hardware mode: pins become straps after a fresh boot
    @(posedge pclk);
    hw_sel <= 1'b1;
    do_reset();
    chk("vout_pu_hw", 1'b0, vout_pu);
    for (int i = 0; i < 6; i++) begin
      w = $random(seed);
      @(posedge pclk);
      {ad0, ad1, ad2} <= w[3:1];
      clear_in <= w[6];
      cvs <= w[7];
      shrt <= w[8];
      host.set_pins(w[4], w[5], w[0]);
      repeat (12) @(posedge pclk);
      chk("hw_range", w[3:0], range_setting);
      chk("hw_oe", w[4], drive_enable);
      chk("hw_rsel", w[5], sense_internal);
      chk("hw_clr", w[6], clr_f);
      chk("hw_mid", w[7], clr_m);
      chk("alert_oe_n", !w[8], so_oe_n);
      chk("alert", 1'b0, serial_out);
    end
    @(posedge pclk);
    hw_sel <= 1'b0;
    repeat (12) @(posedge pclk);
    apb(1'b0, A_STATUS, 32'h0);
    chk("mode", 1'b1, rd[10]);
    finish_test();
  end
endmodule
